/* pkg/sram_pkg.sv */
package sram_pkg;
   // Nine-bit byte lanes, four of them in the wide organisation.
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int DATA_W = LANE_W * LANES;
   // Wide organisation: 256K words of 36 bits.
   localparam int ADDR_W = 18;
   localparam int DEPTH = 1 << ADDR_W;
   // Narrow organisation, kept for reference: 512K words of 18 bits, two lanes.
   localparam int NARROW_ADDR_W = 19;
   localparam int NARROW_LANES = 2;
   // Burst counter.
   localparam int BURST_W = 2;
   localparam int HIGH_W = ADDR_W - BURST_W;
   localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [LANE_W-1:0] LANE_CLEAR = 9'h000;
   // Cycle type held for a burst.
   typedef enum logic [2:0] {
      OP_DESEL = 3'b001,
      OP_READ = 3'b010,
      OP_WRITE = 3'b100
   } op_t;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] word_t;
   typedef logic [LANES-1:0] lanes_t;
endpackage : sram_pkg

/* pkg/sram_mem_if.sv */
`timescale 1ns/1ps
interface sram_mem_if;
   logic we;
   logic re;
   sram_pkg::addr_t addr;
   sram_pkg::word_t wdata;
   sram_pkg::lanes_t laneWe;
   sram_pkg::word_t rdata;
   modport ctrl (output we, output re, output addr, output wdata, output laneWe, input rdata);
   modport array (input we, input re, input addr, input wdata, input laneWe, output rdata);
endinterface : sram_mem_if

/* logic/sram_array.sv */
`timescale 1ns/1ps
module sram_array (
   input wire logic clk_sys,
   input wire logic resetn,
   sram_mem_if.array mem
);
   // One storage array per byte lane, so that a lane write never touches its neighbours.
   genvar g;
   for (g = 0; g < sram_pkg::LANES; g++) begin : laneGen
      logic [sram_pkg::LANE_W-1:0] laneStore [0:sram_pkg::DEPTH-1];
      logic [sram_pkg::LANE_W-1:0] laneRd_r;
      // Unselected lanes keep their old contents.
      always_ff @(posedge clk_sys) begin
         if (mem.we && mem.laneWe[g]) begin
            laneStore[mem.addr] <= mem.wdata[g*sram_pkg::LANE_W +: sram_pkg::LANE_W];
         end
      end
      // Read data leave through a register; it holds while no read is performed.
      always_ff @(posedge clk_sys) begin
         if (!resetn) begin
            laneRd_r <= sram_pkg::LANE_CLEAR;
         end else if (mem.re) begin
            laneRd_r <= laneStore[mem.addr];
         end
      end
      assign mem.rdata[g*sram_pkg::LANE_W +: sram_pkg::LANE_W] = laneRd_r;
   end
endmodule : sram_array

/* logic/sync_burst_sram.sv */
// What this block does
// - Capture all synchronous inputs each rising edge.
// - Array is 256K x 36 in 9-bit lanes.
// - Burst counter starts from two low bits.
// - Load low loads address; high advances internally.
// - Burst order interleaved or linear by input.
// - Read/write low starts a self-timed write.
// - Each lane enable gates its own byte.
// - Cycle type fixed at load, kept through burst.
// - Chip selects sampled only on load edges.
// - Reads and writes alternate with no gaps.
// - Clock gate high suspends all action.
// - Output enable gates drivers asynchronously.
// - Sleep: standby, contents kept, inputs ignored.
// - Advance increments counter, ignores read/write.
// - All lanes enabled writes whole word.
`timescale 1ns/1ps
module sync_burst_sram (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [sram_pkg::HIGH_W-1:0] addrHigh,
   input wire logic addrBitLow0,
   input wire logic addrBitLow1,
   input wire logic chipSelN,
   input wire logic chipSelectDepthPair,
   input wire logic chipSelectDepthPairN,
   input wire logic advanceOrLoad,
   input wire logic readWriteN,
   input wire logic clockGateN,
   input wire logic byteLaneWriteN0,
   input wire logic byteLaneWriteN1,
   input wire logic byteLaneWriteN2,
   input wire logic byteLaneWriteN3,
   input wire logic outputEnableN,
   input wire logic sleepRequest,
   input wire logic burstOrderInterleaved,
   input wire logic [sram_pkg::DATA_W-1:0] dataIn,
   output logic [sram_pkg::DATA_W-1:0] dataOut,
   output logic dataOe
);

   // Next low address bits of a burst; both orders stay inside the four-word group.
   function automatic logic [sram_pkg::BURST_W-1:0] burstLow(
      input logic [sram_pkg::BURST_W-1:0] start,
      input logic [sram_pkg::BURST_W-1:0] cnt,
      input logic interleaved
   );
      logic [sram_pkg::BURST_W-1:0] res;
      res = interleaved ? (start ^ cnt) : sram_pkg::BURST_W'(start + cnt);
      return res;
   endfunction : burstLow

   sram_mem_if memBus ();

   logic sleepMeta_r;
   logic sleepSync_r;
   logic modeMeta_r;
   logic modeSync_r;
   sram_pkg::op_t burstOp_r;
   sram_pkg::op_t pendOp_r;
   logic [sram_pkg::HIGH_W-1:0] base_r;
   logic [sram_pkg::BURST_W-1:0] startLow_r;
   logic [sram_pkg::BURST_W-1:0] cnt_r;
   sram_pkg::addr_t pendAddr_r;
   sram_pkg::lanes_t pendBw_r;
   logic readValid_r;

   // Sleep and burst order are asynchronous pins, so they are synchronised first.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sleepMeta_r <= 1'b0;
         sleepSync_r <= 1'b0;
         modeMeta_r <= 1'b0;
         modeSync_r <= 1'b0;
      end else begin
         sleepMeta_r <= sleepRequest;
         sleepSync_r <= sleepMeta_r;
         modeMeta_r <= burstOrderInterleaved;
         modeSync_r <= modeMeta_r;
      end
   end

   // Edge qualification and the decode of a load edge.
   wire clkGo = !clockGateN && !sleepSync_r;
   wire loadNow = !advanceOrLoad;
   wire selected = !chipSelN && chipSelectDepthPair && !chipSelectDepthPairN;
   wire [sram_pkg::BURST_W-1:0] addrLow = {addrBitLow1, addrBitLow0};
   wire [sram_pkg::BURST_W-1:0] cntInc = cnt_r + sram_pkg::BURST_STEP;
   wire sram_pkg::op_t loadOp = !selected ? sram_pkg::OP_DESEL :
      (readWriteN ? sram_pkg::OP_READ : sram_pkg::OP_WRITE);
   // Read/write select only counts on a load edge; an advance keeps the burst's type.
   wire sram_pkg::op_t burstOp_nxt = loadNow ? loadOp : burstOp_r;
   wire [sram_pkg::BURST_W-1:0] cnt_nxt = loadNow ? sram_pkg::BURST_ZERO : cntInc;
   wire [sram_pkg::BURST_W-1:0] startLow_nxt = loadNow ? addrLow : startLow_r;
   wire [sram_pkg::HIGH_W-1:0] base_nxt = loadNow ? addrHigh : base_r;
   wire sram_pkg::addr_t pendAddr_nxt = {base_nxt, burstLow(startLow_nxt, cnt_nxt, modeSync_r)};
   // Lane enables come with each address and steer the data of the next edge.
   wire sram_pkg::lanes_t pendBw_nxt = ~{byteLaneWriteN3, byteLaneWriteN2, byteLaneWriteN1,
      byteLaneWriteN0};

   // Burst and pending access state; a gated or sleeping edge leaves all of it unchanged.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         burstOp_r <= sram_pkg::OP_DESEL;
         pendOp_r <= sram_pkg::OP_DESEL;
         base_r <= '0;
         startLow_r <= sram_pkg::BURST_ZERO;
         cnt_r <= sram_pkg::BURST_ZERO;
         pendAddr_r <= '0;
         pendBw_r <= '0;
      end else if (clkGo) begin
         burstOp_r <= burstOp_nxt;
         pendOp_r <= burstOp_nxt;
         base_r <= base_nxt;
         startLow_r <= startLow_nxt;
         cnt_r <= cnt_nxt;
         pendAddr_r <= pendAddr_nxt;
         pendBw_r <= pendBw_nxt;
      end
   end

   // The access captured at one edge is carried out at the next, while that edge also
   // takes the next address: this is what lets every clock carry a transfer.
   assign memBus.we = clkGo && (pendOp_r == sram_pkg::OP_WRITE);
   assign memBus.re = clkGo && (pendOp_r == sram_pkg::OP_READ);
   assign memBus.addr = pendAddr_r;
   assign memBus.wdata = dataIn;
   assign memBus.laneWe = pendBw_r;

   sram_array arrayInst (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .mem(memBus)
   );

   // Remembers whether the data register holds a fresh read result.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         readValid_r <= 1'b0;
      end else if (clkGo) begin
         readValid_r <= (pendOp_r == sram_pkg::OP_READ);
      end
   end

   // The output enable pin reaches the drivers without a clock edge, so it is not
   // synchronised; the trade-off is that its glitches reach the drivers too.
   assign dataOut = memBus.rdata;
   assign dataOe = !outputEnableN && readValid_r && !sleepSync_r;

   // A gated edge must not move the burst or the pending access.
   gate_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clockGateN |=> $stable(pendAddr_r) && $stable(cnt_r) && $stable(pendOp_r))
      else $error("State moved on a gated clock edge.");

   // No array activity while gated.
   gate_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clockGateN |-> !memBus.we && !memBus.re)
      else $error("Array accessed while the clock was gated.");

   // A selected load edge takes the external address unchanged.
   load_addr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkGo && loadNow && selected |=>
      pendAddr_r == $past({addrHigh, addrBitLow1, addrBitLow0}) && cnt_r == sram_pkg::BURST_ZERO)
      else $error("Loaded address differs from the pins.");

   // A load fixes the cycle type from read/write select.
   load_type_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkGo && loadNow && selected |=>
      pendOp_r == ($past(readWriteN) ? sram_pkg::OP_READ : sram_pkg::OP_WRITE))
      else $error("Cycle type not taken at load.");

   // An advance counts up by one and keeps the burst's type and selection.
   adv_count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkGo && advanceOrLoad |=> cnt_r == $past(cntInc) && pendOp_r == $past(burstOp_r))
      else $error("Advance did not step the counter or changed the type.");

   // Chip selects changing during an advance do not matter.
   cs_ignore_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkGo && advanceOrLoad && !selected && burstOp_r != sram_pkg::OP_DESEL |=>
      pendOp_r != sram_pkg::OP_DESEL)
      else $error("Chip select sampled during an advance.");

   // Advanced addresses follow the chosen order within the group.
   burst_order_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkGo && advanceOrLoad && $stable(modeSync_r) |=>
      pendAddr_r == {base_r, burstLow(startLow_r, cnt_r, modeSync_r)})
      else $error("Burst address out of order.");

   // A write loaded at one edge is written at the next enabled edge, back to back.
   write_next_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkGo && loadNow && selected && !readWriteN ##1 clkGo |-> memBus.we)
      else $error("Loaded write not performed on the following edge.");

   // A full-width write enables every lane.
   full_word_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkGo && {byteLaneWriteN3, byteLaneWriteN2, byteLaneWriteN1, byteLaneWriteN0} == '0
      |=> pendBw_r == '1)
      else $error("Lane enables lost for a full word write.");

   // In sleep nothing is accessed and the drivers stay off.
   sleep_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      sleepSync_r |-> !memBus.we && !memBus.re && !dataOe)
      else $error("Activity during sleep.");

   // Output enable high always turns the drivers off.
   oe_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      outputEnableN |-> !dataOe)
      else $error("Drivers on with output enable high.");

   // A loaded read is carried out at the next enabled edge, with no wait cycle.
   read_next_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkGo && loadNow && selected && readWriteN ##1 clkGo |-> memBus.re)
      else $error("Loaded read not performed on the following edge.");

   // A deselected load must leave the array alone at the following edge.
   desel_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkGo && loadNow && !selected |=> !memBus.we && !memBus.re)
      else $error("Deselected load reached the array.");

   // Lane enables are latched together with the address of their own edge.
   lane_latch_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkGo |=> pendBw_r == ~$past({byteLaneWriteN3, byteLaneWriteN2, byteLaneWriteN1, byteLaneWriteN0}))
      else $error("Lane enables not taken with their address.");

endmodule : sync_burst_sram

/* sim/ctrl_model.sv */
`timescale 1ns/1ps
// Controller model: every pin except output enable changes just after a rising edge and stands for the whole cycle.
module ctrl_model (
   input wire logic clk_sys
);
   logic [sram_pkg::HIGH_W-1:0] addrHigh = '0;
   logic addrBitLow0 = 1'b0, addrBitLow1 = 1'b0, advanceOrLoad = 1'b1, readWriteN = 1'b1;
   logic chipSelN = 1'b0, clockGateN = 1'b0, outputEnableN = 1'b0, burstOrderInterleaved = 1'b0;
   logic sleepRequest = 1'b0;
   logic chipSelectDepthPair = 1'b1, chipSelectDepthPairN = 1'b0;
   sram_pkg::lanes_t laneN = 4'hf;
   sram_pkg::word_t dataIn = '0;
   // Lane enables leave with their address, while write data trails its address by one cycle.
   task cyc(input logic ld, input logic rwn, input sram_pkg::addr_t a, input sram_pkg::lanes_t bwn,
            input sram_pkg::word_t d);
      @(posedge clk_sys);
      advanceOrLoad <= ~ld;
      readWriteN <= rwn;
      {addrHigh, addrBitLow1, addrBitLow0} <= a;
      laneN <= bwn;
      dataIn <= d;
   endtask : cyc
endmodule : ctrl_model

/* sim/sync_burst_sram_test.sv */
`timescale 1ns/1ps
// Read data of a load shows 1 ns after the second following call, so checks sit there.
module sync_burst_sram_test;
   localparam sram_pkg::addr_t B = 18'h12340;
   localparam sram_pkg::addr_t C = 18'h00a42;
   localparam sram_pkg::addr_t C1 = 18'h00a41;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   sram_pkg::word_t dataOut;
   logic dataOe;
   int n_errors = 0;
   int cmp_count = 0;
   ctrl_model u_ctrl_model (.clk_sys(clk_sys));
   // All three selects come from the controller model, so each can deselect a load.
   sync_burst_sram u_sync_burst_sram (
      .clk_sys(clk_sys), .resetn(resetn), .addrHigh(u_ctrl_model.addrHigh),
      .addrBitLow0(u_ctrl_model.addrBitLow0), .addrBitLow1(u_ctrl_model.addrBitLow1),
      .chipSelN(u_ctrl_model.chipSelN), .chipSelectDepthPair(u_ctrl_model.chipSelectDepthPair),
      .chipSelectDepthPairN(u_ctrl_model.chipSelectDepthPairN),
      .advanceOrLoad(u_ctrl_model.advanceOrLoad), .readWriteN(u_ctrl_model.readWriteN),
      .clockGateN(u_ctrl_model.clockGateN), .byteLaneWriteN0(u_ctrl_model.laneN[0]),
      .byteLaneWriteN1(u_ctrl_model.laneN[1]), .byteLaneWriteN2(u_ctrl_model.laneN[2]),
      .byteLaneWriteN3(u_ctrl_model.laneN[3]), .outputEnableN(u_ctrl_model.outputEnableN),
      .sleepRequest(u_ctrl_model.sleepRequest), .burstOrderInterleaved(u_ctrl_model.burstOrderInterleaved),
      .dataIn(u_ctrl_model.dataIn), .dataOut(dataOut), .dataOe(dataOe));
   // Clock at 125 MHz.
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   // Case inequality, so an unknown never passes.
   task chk(input sram_pkg::word_t seen, input sram_pkg::word_t exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task cy(input logic ld, input logic rwn, input sram_pkg::addr_t a, input sram_pkg::lanes_t bwn,
           input sram_pkg::word_t d);
      u_ctrl_model.cyc(ld, rwn, a, bwn, d);
   endtask : cy
   task idle(input int n);
      repeat (n) cy(1'b1, 1'b1, C, 4'hf, '0);
   endtask : idle
   function automatic sram_pkg::word_t w(input logic [8:0] v);
      return {4{v}};
   endfunction : w
   task conclude();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   // Write, read, write, read on consecutive edges with no idle cycle between them.
   task t_alternate();
      cy(1'b1, 1'b0, B, 4'h0, '0);
      cy(1'b1, 1'b1, B, 4'hf, w(9'h0a5));
      cy(1'b1, 1'b0, B + 18'h1, 4'h0, '0);
      cy(1'b1, 1'b1, B + 18'h1, 4'hf, w(9'h15a));
      #1 chk(dataOut, w(9'h0a5));
      idle(2);
      #1 chk(dataOut, w(9'h15a));
      chk({35'h0, dataOe}, 36'h1);
      // Output enable moves between edges, so only an asynchronous path can follow it.
      u_ctrl_model.outputEnableN <= 1'b1;
      #1 chk({35'h0, dataOe}, 36'h0);
      u_ctrl_model.outputEnableN <= 1'b0;
      $display("done alternate");
   endtask : t_alternate
   // Lanes 0 and 2 written, lanes 1 and 3 keep the old byte.
   task t_lanes();
      cy(1'b1, 1'b0, B, 4'ha, '0);
      cy(1'b1, 1'b1, B, 4'hf, w(9'h1ff));
      idle(2);
      #1 chk(dataOut, {9'h0a5, 9'h1ff, 9'h0a5, 9'h1ff});
      $display("done lanes");
   endtask : t_lanes
   // Burst from low bits 1; read/write held low on advances must not turn it into a write.
   task burst_read(input logic il);
      int l;
      u_ctrl_model.burstOrderInterleaved <= il;
      idle(3);
      for (int i = 0; i < 6; i++) begin
         cy(i == 0, i == 0, C1, 4'hf, '0);
         l = il ? (1 ^ (i - 2)) : ((i - 1) & 3);
         if (i >= 2)
            #1 chk(dataOut, w(9'h0c0 + 9'((l + 2) & 3)));
      end
   endtask : burst_read
   // Word k of a write burst from low bits 2 lands at low bits (2 + k) mod 4.
   task t_burst();
      for (int i = 0; i < 5; i++)
         cy(i % 4 == 0, i != 0, C, 4'h0, w(9'h0bf + 9'(i)));
      burst_read(1'b0);
      burst_read(1'b1);
      u_ctrl_model.burstOrderInterleaved <= 1'b0;
      idle(3);
      $display("done burst");
   endtask : t_burst
   // A gated edge carries a write that must vanish and must not advance the pending read.
   task t_gate();
      cy(1'b1, 1'b1, C1, 4'hf, '0);
      cy(1'b1, 1'b0, C1, 4'h0, '0);
      u_ctrl_model.clockGateN <= 1'b1;
      cy(1'b0, 1'b1, C1, 4'hf, '0);
      u_ctrl_model.clockGateN <= 1'b0;
      cy(1'b1, 1'b1, C1, 4'hf, '0);
      #1 chk(dataOut, w(9'h0c3));
      idle(1);
      #1 chk(dataOut, w(9'h0c0));
      idle(1);
      #1 chk(dataOut, w(9'h0c3));
      $display("done gate");
   endtask : t_gate
   // Writes deselected by each select in turn do nothing; deselect during an advance is ignored.
   // A select change is made right after the call whose pins it must accompany.
   task t_select();
      cy(1'b1, 1'b0, C1, 4'h0, '0);
      u_ctrl_model.chipSelN <= 1'b1;
      cy(1'b1, 1'b0, C1, 4'h0, '0);
      u_ctrl_model.chipSelN <= 1'b0;
      u_ctrl_model.chipSelectDepthPair <= 1'b0;
      cy(1'b1, 1'b0, C1, 4'h0, '0);
      u_ctrl_model.chipSelectDepthPair <= 1'b1;
      u_ctrl_model.chipSelectDepthPairN <= 1'b1;
      cy(1'b1, 1'b1, C1, 4'hf, '0);
      u_ctrl_model.chipSelectDepthPairN <= 1'b0;
      cy(1'b0, 1'b1, C1, 4'hf, '0);
      u_ctrl_model.chipSelN <= 1'b1;
      cy(1'b0, 1'b1, C1, 4'hf, '0);
      u_ctrl_model.chipSelN <= 1'b0;
      #1 chk(dataOut, w(9'h0c3));
      idle(1);
      #1 chk(dataOut, w(9'h0c0));
      $display("done select");
   endtask : t_select
   // Writes during standby are ignored and the array keeps its contents.
   task t_sleep();
      u_ctrl_model.sleepRequest <= 1'b1;
      idle(3);
      repeat (3) cy(1'b1, 1'b0, C1, 4'h0, '0);
      idle(3);
      #1 chk({35'h0, dataOe}, 36'h0);
      u_ctrl_model.sleepRequest <= 1'b0;
      idle(3);
      cy(1'b1, 1'b1, C1, 4'hf, '0);
      idle(2);
      #1 chk(dataOut, w(9'h0c3));
      $display("done sleep");
   endtask : t_sleep
   // Reset held for 16 edges, then the scenarios in turn.
   initial begin
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      t_alternate();
      t_lanes();
      t_burst();
      t_gate();
      t_select();
      t_sleep();
      conclude();
   end
endmodule : sync_burst_sram_test
